// File: rtl/limit_check.sv
// Per-channel limit comparison with consecutive out-of-limit filter.
// Assumes upd is a one-cycle pulse with a stable corrected reading.
`timescale 1ns/1ps
module limit_check
	import temp_alert_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       upd,
	input  wire temp_t      temp,
	input  wire temp_t      hi_lim,
	input  wire temp_t      lo_lim,
	input  wire logic [2:0] need,
	output logic            hi_trip,
	output logic            lo_trip
);

	limit_state_t st_r;
	limit_state_t st_nxt;
	logic         above;
	logic         below;

	always_comb begin
		st_nxt = st_r;
		above  = temp > hi_lim;
		below  = temp <= lo_lim;
		if (upd) begin
			if (above || below) begin
				if (st_r.cnt < need)
					st_nxt.cnt = st_r.cnt + 3'h1;
			end else begin
				st_nxt.cnt = 3'h0;
			end
			st_nxt.hi = above && (st_nxt.cnt >= need);
			st_nxt.lo = below && (st_nxt.cnt >= need);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign hi_trip = st_r.hi;
	assign lo_trip = st_r.lo;

endmodule // limit_check

// File: rtl/overtemp_output_hyst.sv
// Over-temperature comparator with hysteresis below the limit.
// Assumes hysteresis is whole degrees, unsigned.
`timescale 1ns/1ps
module overtemp_output_hyst
	import temp_alert_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       upd,
	input  wire temp_t      temp,
	input  wire temp_t      limit,
	input  wire logic [7:0] hyst,
	output logic            over
);

	hyst_state_t       st_r;
	hyst_state_t       st_nxt;
	logic signed [11:0] release_at;

	always_comb begin
		st_nxt     = st_r;
		release_at = {{2{limit[9]}}, limit} - $signed({2'h0, hyst, 2'h0});
		if (upd) begin
			if (temp > limit)
				st_nxt.over = 1'b1;
			else if ($signed({{2{temp[9]}}, temp}) < release_at)
				st_nxt.over = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign over = st_r.over;

endmodule // overtemp_output_hyst

// File: rtl/temp_alert_params.svh
// Constants of the status, alarm and offset logic of the monitor.
// Assumes the bus engine hands over byte register accesses as pulses.
//
// Operation
// - Two read-only status registers, 0x02 and 0x23.
// - Status one bit 7 shows busy; no alert.
// - Bits 6..3 flag local/remote-one limit trips.
// - Bit 2 flags open remote sensor, both registers.
// - Overtemp flags in bits 1,0; never drive alert.
// - Status two bits 4,3 trips; 7..5 read zero.
// - Trip and open flags stay set until read or reset.
// - Any unmasked alert flag sets latch, pin low outside second overtemp mode.
// - Status one read clears bits 6..2 if gone.
// - Status two read clears bits 4..2 if gone.
// - Latch clears only on alert response, flags clear.
// - Overtemp pin low while any overtemp flag set.
// - Overtemp releases below limit minus hysteresis.
// - Second overtemp mode uses only high-limit trips.
// - Status two bit 0 mirrors the alert latch.
// - Offsets 10-bit signed at 0x11/0x12, 0x34/0x35.
// - Low byte top two bits, quarter degree steps.
// - Config bit 3 steers 0x11/0x12 to remote two.
// - Offset added to remote readings, resets to zero.
// - Write to 0x0F starts one conversion, data dropped.
// - High trips on greater, low on less-or-equal.
// - Alert after one to four consecutive out-of-limits.
`ifndef TEMP_ALERT_PARAMS_SVH
`define TEMP_ALERT_PARAMS_SVH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_STATUS_ONE      8'h02
`define ADDR_ONESHOT         8'h0f
`define ADDR_OFF_HIGH        8'h11
`define ADDR_OFF_LOW         8'h12
`define ADDR_STATUS_TWO      8'h23
`define ADDR_OFF_TWO_HIGH    8'h34
`define ADDR_OFF_TWO_LOW     8'h35

// ****************************************
// Fields and reset values
// ****************************************
`define OFF_LOW_MSB          7
`define OFF_LOW_LSB          6
`define OFF_HIGH_RESET       8'h00
`define OFF_LOW_RESET        2'h0
`define RDATA_RESET          8'h00
`define STATUS_TWO_RSVD      3'h0
`define TEMP_MAX             10'h1ff
`define TEMP_MIN             10'h200

`endif

// File: rtl/temp_alert_pkg.sv
// Types shared by the status, alarm and offset logic.
// Assumes temperatures are signed quarter degrees, ten bits wide.
package temp_alert_pkg;

	typedef logic signed [9:0] temp_t;

	// Channel codes from the conversion engine, Gray along round robin
	typedef enum logic [1:0] {
		chan_local      = 2'h0,
		chan_remote_one = 2'h1,
		chan_remote_two = 2'h3
	} chan_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic       hi;
		logic       lo;
	} limit_state_t;

	typedef struct packed {
		logic over;
	} hyst_state_t;

	typedef struct packed {
		logic [1:0][7:0] off_hi;
		logic [1:0][1:0] off_lo;
		temp_t           corr;
		chan_t           corr_ch;
		logic            corr_vld;
		logic [1:0]      open;
		logic            eval;
		chan_t           eval_ch;
		logic [4:0]      s1_flags;
		logic [2:0]      s2_flags;
		logic            latch;
		logic            alert_n;
		logic            overtemp_output_n;
		logic [7:0]      rdata;
		logic            oneshot;
	} core_state_t;

endpackage

// File: rtl/temp_status_alert_offset_logic.sv
// Status flags, alert latch, overtemp outputs and remote offsets.
// Assumes register strobes and conversion results on sys_clk.
`timescale 1ns/1ps
`include "temp_alert_params.svh"
module temp_status_alert_offset_logic
	import temp_alert_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic            nrst,
	input  wire logic [7:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	input  wire logic            alert_resp,
	input  wire logic            conv_busy,
	input  wire logic            conv_done,
	input  wire chan_t           conv_chan,
	input  wire temp_t           conv_temp,
	input  wire logic            conv_open,
	input  wire logic [2:0][9:0] high_limit,
	input  wire logic [2:0][9:0] low_limit,
	input  wire logic [2:0][9:0] overtemp_output_limit,
	input  wire logic [7:0]      overtemp_output_hyst_val,
	input  wire logic [2:0]      consec_cfg,
	input  wire logic            alert_mask,
	input  wire logic            second_overtemp_output_mode,
	input  wire logic            offset_sel,
	output logic [7:0]           reg_rdata,
	output logic                 alert_n,
	output logic                 overtemp_n,
	output logic                 oneshot_start,
	output logic [9:0]           corr_temp,
	output logic [1:0]           corr_chan,
	output logic                 corr_valid
);

	// ****************************************
	// Declarations
	// ****************************************
	core_state_t  st_r;
	core_state_t  st_nxt;
	logic [2:0]   hi_trip;
	logic [2:0]   lo_trip;
	logic [2:0]   over_flag;
	logic [2:0]   over_high;
	logic [2:0]   ch_upd;
	logic [2:0]   need;
	logic [2:0]   ev_ch;
	logic [4:0]   cond1;
	logic [2:0]   cond2;
	logic [4:0]   set1;
	logic [2:0]   set2;
	logic [7:0]   status_one;
	logic [7:0]   status_two;
	logic         rd_s1;
	logic         rd_s2;
	logic         any_flag;
	logic         off_idx;
	logic [9:0]   off_val;
	logic [10:0]  sum;

	// ****************************************
	// Per-channel comparison
	// ****************************************
	assign need = 3'h1 + {2'h0, consec_cfg[0]} + {2'h0, consec_cfg[1]}
		+ {2'h0, consec_cfg[2]};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_chan
			assign ch_upd[gi] = st_r.corr_vld
				&& (st_r.corr_ch == chan_t'(gi == 2 ? 3 : gi));

			limit_check u_limit (
				.sys_clk (sys_clk),
				.nrst    (nrst),
				.upd     (ch_upd[gi]),
				.temp    (st_r.corr),
				.hi_lim  (high_limit[gi]),
				.lo_lim  (low_limit[gi]),
				.need    (need),
				.hi_trip (hi_trip[gi]),
				.lo_trip (lo_trip[gi])
			);

			overtemp_output_hyst u_overtemp_output (
				.sys_clk (sys_clk),
				.nrst    (nrst),
				.upd     (ch_upd[gi]),
				.temp    (st_r.corr),
				.limit   (overtemp_output_limit[gi]),
				.hyst    (overtemp_output_hyst_val),
				.over    (over_flag[gi])
			);

			overtemp_output_hyst u_second_overtemp_output (
				.sys_clk (sys_clk),
				.nrst    (nrst),
				.upd     (ch_upd[gi]),
				.temp    (st_r.corr),
				.limit   (high_limit[gi]),
				.hyst    (overtemp_output_hyst_val),
				.over    (over_high[gi])
			);
		end
	endgenerate

	// ****************************************
	// Status views
	// ****************************************
	assign ev_ch[0] = st_r.eval && (st_r.eval_ch == chan_local);
	assign ev_ch[1] = st_r.eval && (st_r.eval_ch == chan_remote_one);
	assign ev_ch[2] = st_r.eval && (st_r.eval_ch == chan_remote_two);

	// Current cause of each sticky flag
	assign cond1 = {hi_trip[0], lo_trip[0], hi_trip[1], lo_trip[1],
		st_r.open[0]};
	assign cond2 = {hi_trip[2], lo_trip[2], st_r.open[1]};
	assign set1  = cond1 & {ev_ch[0], ev_ch[0], ev_ch[1], ev_ch[1],
		ev_ch[1]};
	assign set2  = cond2 & {3{ev_ch[2]}};

	assign status_one = {conv_busy, st_r.s1_flags,
		over_flag[1], over_flag[0]};
	assign status_two = {`STATUS_TWO_RSVD, st_r.s2_flags,
		over_flag[2], st_r.latch};

	assign rd_s1 = reg_rd && (reg_addr == `ADDR_STATUS_ONE);
	assign rd_s2 = reg_rd && (reg_addr == `ADDR_STATUS_TWO);

	// Only limit and open flags feed the alert
	assign any_flag = |{st_r.s1_flags, st_r.s2_flags};

	// ****************************************
	// Offset correction
	// ****************************************
	assign off_idx = (conv_chan == chan_remote_two);
	assign off_val = {st_r.off_hi[off_idx], st_r.off_lo[off_idx]};
	assign sum     = {conv_temp[9], conv_temp} + {off_val[9], off_val};

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt          = st_r;
		st_nxt.oneshot  = 1'b0;
		st_nxt.corr_vld = conv_done;
		st_nxt.eval     = st_r.corr_vld;
		st_nxt.eval_ch  = st_r.corr_ch;

		// Stage the corrected reading
		if (conv_done) begin
			st_nxt.corr_ch = conv_chan;
			if (conv_chan == chan_local)
				st_nxt.corr = conv_temp;
			else if (sum[10] != sum[9])
				st_nxt.corr = sum[10] ? `TEMP_MIN : `TEMP_MAX;
			else
				st_nxt.corr = temp_t'(sum[9:0]);
			if (conv_chan == chan_remote_one)
				st_nxt.open[0] = conv_open;
			if (conv_chan == chan_remote_two)
				st_nxt.open[1] = conv_open;
		end

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				`ADDR_ONESHOT:
					st_nxt.oneshot = 1'b1;
				`ADDR_OFF_HIGH:
					st_nxt.off_hi[offset_sel] = reg_wdata;
				`ADDR_OFF_LOW:
					st_nxt.off_lo[offset_sel] =
						reg_wdata[`OFF_LOW_MSB:`OFF_LOW_LSB];
				`ADDR_OFF_TWO_HIGH:
					st_nxt.off_hi[1] = reg_wdata;
				`ADDR_OFF_TWO_LOW:
					st_nxt.off_lo[1] =
						reg_wdata[`OFF_LOW_MSB:`OFF_LOW_LSB];
				default: ;
			endcase
		end

		// Register reads
		if (reg_rd) begin
			case (reg_addr)
				`ADDR_STATUS_ONE:
					st_nxt.rdata = status_one;
				`ADDR_STATUS_TWO:
					st_nxt.rdata = status_two;
				`ADDR_OFF_HIGH:
					st_nxt.rdata = st_r.off_hi[offset_sel];
				`ADDR_OFF_LOW:
					st_nxt.rdata = {st_r.off_lo[offset_sel], 6'h00};
				`ADDR_OFF_TWO_HIGH:
					st_nxt.rdata = st_r.off_hi[1];
				`ADDR_OFF_TWO_LOW:
					st_nxt.rdata = {st_r.off_lo[1], 6'h00};
				default:
					st_nxt.rdata = `RDATA_RESET;
			endcase
		end

		// Sticky flags: read clears gone causes, a new set wins
		if (rd_s1)
			st_nxt.s1_flags = st_r.s1_flags & cond1;
		if (rd_s2)
			st_nxt.s2_flags = st_r.s2_flags & cond2;
		st_nxt.s1_flags = st_nxt.s1_flags | set1;
		st_nxt.s2_flags = st_nxt.s2_flags | set2;

		// Alert latch survives status reads
		if (alert_resp && !any_flag)
			st_nxt.latch = 1'b0;
		if (any_flag && !alert_mask)
			st_nxt.latch = 1'b1;

		if (second_overtemp_output_mode)
			st_nxt.alert_n = ~|over_high;
		else
			st_nxt.alert_n = ~st_r.latch;
		st_nxt.overtemp_output_n = ~|over_flag;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r         <= '0;
			st_r.off_hi  <= {2{`OFF_HIGH_RESET}};
			st_r.off_lo  <= {2{`OFF_LOW_RESET}};
			st_r.rdata   <= `RDATA_RESET;
			st_r.alert_n <= 1'b1;
			st_r.overtemp_output_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata     = st_r.rdata;
	assign alert_n       = st_r.alert_n;
	assign overtemp_n    = st_r.overtemp_output_n;
	assign oneshot_start = st_r.oneshot;
	assign corr_temp     = st_r.corr;
	assign corr_chan     = st_r.corr_ch;
	assign corr_valid    = st_r.corr_vld;

endmodule // temp_status_alert_offset_logic

// File: verification/host_alert_model.sv
// Host side model: answers the alert with a device address read.
// Assumes svc is a one-cycle request from the bench.
`timescale 1ns/1ps
module host_alert_model (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic svc,
	input  wire logic alert_n,
	output logic      alert_resp
);
	// Address read only while the alert pin is low
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			alert_resp <= 1'b0;
		end else begin
			alert_resp <= svc && !alert_n;
		end
	end
endmodule // host_alert_model

// File: verification/temp_alert_assertions.sv
// Port checker of the status, alert and offset logic.
// Assumes it is bound onto the top module of the block.
`timescale 1ns/1ps
module temp_alert_checker (
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic       alert_resp,
	input wire logic       conv_busy,
	input wire logic       conv_done,
	input wire logic       alert_mask,
	input wire logic       second_overtemp_output_mode,
	input wire logic [7:0] reg_rdata,
	input wire logic       alert_n,
	input wire logic       overtemp_n,
	input wire logic       oneshot_start,
	input wire logic       corr_valid
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	a_oneshot_pulse: assert property (
		oneshot_start == $past(reg_wr && reg_addr == 8'h0f))
		else $error("start pulse not tied to trigger write");
	a_trigger_not_stored: assert property (
		reg_rd && reg_addr == 8'h0f |=> reg_rdata == 8'h00)
		else $error("trigger address read back data");
	a_corr_follows: assert property (
		corr_valid == $past(conv_done))
		else $error("corrected reading not one cycle after done");
	a_busy_live: assert property (
		reg_rd && reg_addr == 8'h02 |=> reg_rdata[7] == $past(conv_busy))
		else $error("busy bit differs from converter");
	a_reserved_zero: assert property (
		reg_rd && reg_addr == 8'h23 |=> reg_rdata[7:5] == 3'h0)
		else $error("reserved status bits not zero");
	a_alert_bit_mirror: assert property (
		reg_rd && reg_addr == 8'h23 |=> reg_rdata[0] == !alert_n)
		else $error("alert status bit differs from pin");
	a_release_serviced: assert property (
		$rose(alert_n) && !$past(second_overtemp_output_mode) |-> $past(alert_resp, 2))
		else $error("alert released without service");
	a_mask_holds: assert property (
		alert_mask ##1 alert_n |=> alert_n)
		else $error("masked alert asserted");

	c_alert: cover property ($fell(alert_n));
	c_overtemp: cover property ($fell(overtemp_n));
	c_service: cover property (alert_resp && !alert_n);
endmodule // temp_alert_checker

bind temp_status_alert_offset_logic temp_alert_checker u_temp_alert_checker (
	.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .alert_resp(alert_resp), .conv_busy(conv_busy),
	.conv_done(conv_done), .alert_mask(alert_mask),
	.second_overtemp_output_mode(second_overtemp_output_mode), .reg_rdata(reg_rdata),
	.alert_n(alert_n), .overtemp_n(overtemp_n),
	.oneshot_start(oneshot_start), .corr_valid(corr_valid)
);

// File: verification/temp_status_alert_offset_logic_bench.sv
// Bench of the status, alert and offset logic.
// Assumes package, header, design, model and checker compiled first.
`timescale 1ns/1ps
module temp_status_alert_offset_logic_bench;
	import temp_alert_pkg::*;
	logic            sys_clk, nrst, reg_wr, reg_rd, svc, conv_done;
	logic            conv_busy, mask, sel, conv_open, alert_resp;
	logic            alert_n, overtemp_n, oneshot_start, corr_valid;
	logic [7:0]      reg_addr, reg_wdata, reg_rdata;
	logic [9:0]      corr_temp;
	logic [2:0][9:0] high_limit, low_limit;
	logic            second_overtemp_output;
	logic [2:0]      consec;
	logic [1:0]      corr_chan;
	temp_t           conv_temp;
	chan_t           conv_chan;
	int              failures, cmp_count, cycles;

	temp_status_alert_offset_logic u_temp_status_alert_offset_logic (
		.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.alert_resp(alert_resp), .conv_busy(conv_busy),
		.conv_done(conv_done), .conv_chan(conv_chan),
		.conv_temp(conv_temp), .conv_open(conv_open),
		.high_limit(high_limit), .low_limit(low_limit),
		.overtemp_output_limit({10'h1ff, 10'h1ff, 10'h140}),
		.overtemp_output_hyst_val(8'h0a), .consec_cfg(consec), .alert_mask(mask),
		.second_overtemp_output_mode(second_overtemp_output), .offset_sel(sel), .reg_rdata(reg_rdata),
		.alert_n(alert_n), .overtemp_n(overtemp_n),
		.oneshot_start(oneshot_start), .corr_temp(corr_temp),
		.corr_chan(corr_chan), .corr_valid(corr_valid)
	);
	host_alert_model u_host_alert_model (
		.sys_clk(sys_clk), .nrst(nrst), .svc(svc), .alert_n(alert_n),
		.alert_resp(alert_resp)
	);

	task automatic chk(input string what, input logic [9:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge sys_clk) reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge sys_clk) reg_rd <= 1'b0;
		#1 chk("reg_rdata", reg_rdata, exp);
	endtask
	task automatic conv(input chan_t c, input logic [9:0] t, input logic o,
		input logic [9:0] exp);
		@(posedge sys_clk) begin
			{conv_done, conv_temp, conv_open} <= {1'b1, t, o};
			conv_chan <= c;
		end
		@(posedge sys_clk) conv_done <= 1'b0;
		#1 chk("corr_temp", corr_temp, exp);
		chk("corr_chan", corr_chan, c);
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	task automatic service;
		@(posedge sys_clk) svc <= 1'b1;
		@(posedge sys_clk) svc <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			close_out;
		end
	end

	initial begin
		{nrst, reg_wr, reg_rd, svc, conv_done, conv_busy, conv_open} = '0;
		{reg_addr, reg_wdata, conv_temp, sel} = '0;
		mask = 1'b1;
		conv_chan = chan_local;
		high_limit = {3{10'h1ff}};
		low_limit = {3{10'h200}};
		{second_overtemp_output, consec} = '0;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(8'h11, 8'h00);
		rd(8'h35, 8'h00);
		rd(8'h23, 8'h00);
		rd(8'h02, 8'h00);
		$display("test reset done");
		wr(8'h11, 8'h04);
		wr(8'h12, 8'hff);
		rd(8'h12, 8'hc0);
		wr(8'h02, 8'hff);
		rd(8'h02, 8'h00);
		sel <= 1'b1;
		wr(8'h11, 8'hfc);
		wr(8'h12, 8'h00);
		sel <= 1'b0;
		rd(8'h34, 8'hfc);
		rd(8'h11, 8'h04);
		conv(chan_remote_one, 10'h050, 1'b0, 10'h063);
		conv(chan_remote_two, 10'h050, 1'b0, 10'h040);
		conv(chan_remote_one, 10'h1f0, 1'b0, 10'h1ff);
		$display("test offsets done");
		wr(8'h0f, 8'h5a);
		chk("oneshot_start", oneshot_start, 1'b1);
		rd(8'h0f, 8'h00);
		$display("test trigger done");
		high_limit[0] <= 10'h100;
		conv_busy <= 1'b1;
		conv(chan_local, 10'h101, 1'b0, 10'h101);
		chk("alert_n", alert_n, 1'b1);
		rd(8'h23, 8'h00);
		rd(8'h02, 8'hc0);
		mask <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 chk("alert_n", alert_n, 1'b0);
		rd(8'h23, 8'h01);
		service;
		chk("alert_n", alert_n, 1'b0);
		conv_busy <= 1'b0;
		conv(chan_local, 10'h100, 1'b0, 10'h100);
		rd(8'h02, 8'h40);
		rd(8'h02, 8'h00);
		chk("alert_n", alert_n, 1'b0);
		service;
		chk("alert_n", alert_n, 1'b1);
		$display("test alert done");
		conv(chan_remote_two, 10'h050, 1'b1, 10'h040);
		rd(8'h23, 8'h05);
		conv(chan_remote_two, 10'h050, 1'b0, 10'h040);
		rd(8'h23, 8'h05);
		rd(8'h23, 8'h01);
		service;
		$display("test open sensor done");
		high_limit[0] <= 10'h1ff;
		conv(chan_local, 10'h141, 1'b0, 10'h141);
		chk("overtemp_n", overtemp_n, 1'b0);
		chk("alert_n", alert_n, 1'b1);
		rd(8'h02, 8'h01);
		conv(chan_local, 10'h118, 1'b0, 10'h118);
		chk("overtemp_n", overtemp_n, 1'b0);
		conv(chan_local, 10'h117, 1'b0, 10'h117);
		chk("overtemp_n", overtemp_n, 1'b1);
		$display("test overtemp done");
		consec <= 3'h1;
		low_limit[1] <= 10'h000;
		conv(chan_remote_one, 10'h3e0, 1'b0, 10'h3f3);
		rd(8'h02, 8'h00);
		conv(chan_remote_one, 10'h3ed, 1'b0, 10'h000);
		rd(8'h02, 8'h08);
		chk("alert_n", alert_n, 1'b0);
		conv(chan_remote_one, 10'h050, 1'b0, 10'h063);
		rd(8'h02, 8'h08);
		rd(8'h02, 8'h00);
		service;
		chk("alert_n", alert_n, 1'b1);
		$display("test consecutive done");
		consec <= 3'h0;
		second_overtemp_output <= 1'b1;
		high_limit[0] <= 10'h100;
		conv(chan_local, 10'h101, 1'b0, 10'h101);
		chk("alert_n", alert_n, 1'b0);
		conv(chan_local, 10'h0d7, 1'b0, 10'h0d7);
		chk("alert_n", alert_n, 1'b1);
		rd(8'h02, 8'h40);
		second_overtemp_output <= 1'b0;
		service;
		chk("alert_n", alert_n, 1'b1);
		$display("test second overtemp done");
		close_out;
	end
endmodule // temp_status_alert_offset_logic_bench
